// file: logic/drr_pkg.sv
// Package for the DRAM refresh and self-refresh control block.
// Assumes a single 20 MHz system clock; timings given in ns.
package drr_pkg;
    // Clock
    localparam int CLK_PERIOD_NS = 50;
    // Timing figures in ns (plain defaults)
    localparam int REFRESH_CYCLE_NS      = 160;
    localparam int CKE_MIN_PULSE_NS      = 5000;
    localparam int SR_EXIT_DELAY_NS      = 170;
    localparam int SR_EXIT_DLL_NS        = 25600;
    localparam int INT_REFRESH_PERIOD_NS = 3900;
    // Cycle counts: least times round up
    localparam int REFRESH_CYCLES  =
        (REFRESH_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CKE_MIN_CYCLES  =
        (CKE_MIN_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SR_EXIT_CYCLES  =
        (SR_EXIT_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SR_DLL_CYCLES   =
        (SR_EXIT_DLL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // Longest time: rounds down
    localparam int INT_REF_CYCLES  = INT_REFRESH_PERIOD_NS / CLK_PERIOD_NS;
    // Counter widths
    localparam int TMR_W = 16;
    localparam int ROW_W = 15;
    localparam logic [ROW_W-1:0] ROW_RESET = 15'h0000;
    // Device states, one-hot
    typedef enum logic [3:0] {
        ST_IDLE    = 4'h1,
        ST_REFRESH = 4'h2,
        ST_SELF    = 4'h4,
        ST_EXIT    = 4'h8
    } drr_state_t;
endpackage

// file: logic/drr_refresh_ctrl.sv
// Refresh and self-refresh control inside the DRAM device.
// Assumes the controller keeps its timing and command-order duties;
// command pins are synchronous to clk_sys.
//
// How it works
// - CS, RAS, CAS low, WE high with CKE high decodes auto refresh.
// - Refresh rows come from the internal counter; address and bank ignored.
// - Refresh completion leaves every bank precharged and idle.
// - Same pins with CKE low decode self-refresh entry.
// - In self-refresh only CKE and reset are heeded.
// - DLL goes off on self-refresh entry, on with reset at exit.
// - One internal refresh within cke_min_pulse; stay at least that long.
// - Exit is CKE rising alone, no NOP decoded; exit delays gate ready flags.
`timescale 1ns/1ps
module drr_refresh_ctrl #(
    parameter int CKE_MIN = drr_pkg::CKE_MIN_CYCLES,
    parameter int DLL_DLY = drr_pkg::SR_DLL_CYCLES
) (
    // Clock and reset
    input  wire logic                     clk_sys,
    input  wire logic                     srst,
    // Command pins
    input  wire logic                     cke,
    input  wire logic                     cs_n,
    input  wire logic                     ras_n,
    input  wire logic                     cas_n,
    input  wire logic                     we_n,
    input  wire logic                     odt,
    // Refresh row output to the array
    output logic [drr_pkg::ROW_W-1:0]     refresh_row,
    output logic                          refresh_strobe,
    // Status
    output logic                          banks_idle,
    output logic                          in_self_refresh,
    output logic                          dll_enable,
    output logic                          dll_reset,
    output logic                          odt_active,
    output logic                          cmd_ready,
    output logic                          dll_cmd_ready
);
    drr_pkg::drr_state_t state;
    drr_pkg::drr_state_t next_state;
    logic [drr_pkg::TMR_W-1:0] tmr;
    logic [drr_pkg::TMR_W-1:0] sr_tmr;
    logic [drr_pkg::TMR_W-1:0] dll_tmr;
    logic                      sr_refreshed;
    logic                      cmd_ref;
    logic                      cmd_sre;
    logic                      cke_q;

    // Shared decode for the two refresh encodings
    function automatic logic ref_code(input logic c, r, a, w);
        return !c && !r && !a && w;
    endfunction

    // Command decode, ignored outside idle
    assign cmd_ref = (state == drr_pkg::ST_IDLE) && cke && cke_q &&
                     ref_code(cs_n, ras_n, cas_n, we_n);
    assign cmd_sre = (state == drr_pkg::ST_IDLE) && !cke && cke_q &&
                     ref_code(cs_n, ras_n, cas_n, we_n);

    // Previous CKE, needed to spot its edges
    always_ff @(posedge clk_sys) begin
        if (srst) cke_q <= 1'b0;
        else      cke_q <= cke;
    end

    // Next state; self-refresh only leaves on CKE
    always_comb begin
        next_state = state;
        case (state)
            drr_pkg::ST_IDLE: begin
                if (cmd_ref)      next_state = drr_pkg::ST_REFRESH;
                else if (cmd_sre) next_state = drr_pkg::ST_SELF;
            end
            drr_pkg::ST_REFRESH: begin
                if (tmr == drr_pkg::TMR_W'(1))
                    next_state = drr_pkg::ST_IDLE;
            end
            drr_pkg::ST_SELF: begin
                // Early CKE rise is held off until the minimum stay ends
                if (cke && sr_tmr == '0 && sr_refreshed)
                    next_state = drr_pkg::ST_EXIT;
            end
            drr_pkg::ST_EXIT: begin
                if (tmr == drr_pkg::TMR_W'(1))
                    next_state = drr_pkg::ST_IDLE;
            end
            default: next_state = drr_pkg::ST_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (srst) state <= drr_pkg::ST_IDLE;
        else      state <= next_state;
    end

    // Busy timer for refresh cycle and exit delay
    always_ff @(posedge clk_sys) begin
        if (srst)
            tmr <= '0;
        else if (cmd_ref)
            tmr <= drr_pkg::TMR_W'(drr_pkg::REFRESH_CYCLES);
        else if (state == drr_pkg::ST_SELF &&
                 next_state == drr_pkg::ST_EXIT)
            tmr <= drr_pkg::TMR_W'(drr_pkg::SR_EXIT_CYCLES);
        else if (tmr != '0)
            tmr <= tmr - drr_pkg::TMR_W'(1);
    end

    // Self-refresh residency and first internal refresh flag
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            sr_tmr       <= '0;
            sr_refreshed <= 1'b0;
        end else if (cmd_sre) begin
            sr_tmr       <= drr_pkg::TMR_W'(CKE_MIN);
            sr_refreshed <= 1'b0;
        end else if (state == drr_pkg::ST_SELF) begin
            if (sr_tmr != '0) sr_tmr <= sr_tmr - drr_pkg::TMR_W'(1);
            if (refresh_strobe) sr_refreshed <= 1'b1;
        end
    end

    // Internal refresh timer in self-refresh; first one fires at once.
    // Reload is one short because the zero cycle counts in the period.
    logic [drr_pkg::TMR_W-1:0] int_tmr;
    always_ff @(posedge clk_sys) begin
        if (srst || state != drr_pkg::ST_SELF)
            int_tmr <= '0;
        else if (int_tmr == '0)
            int_tmr <= drr_pkg::TMR_W'(drr_pkg::INT_REF_CYCLES - 1);
        else
            int_tmr <= int_tmr - drr_pkg::TMR_W'(1);
    end

    // Row counter advances on every refresh, external address unused
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            refresh_row    <= drr_pkg::ROW_RESET;
            refresh_strobe <= 1'b0;
        end else begin
            refresh_strobe <= cmd_ref ||
                (state == drr_pkg::ST_SELF && int_tmr == '0);
            if (refresh_strobe)
                refresh_row <= refresh_row + drr_pkg::ROW_W'(1);
        end
    end

    // DLL off in self-refresh, reset pulse and relock delay on exit
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            dll_enable <= 1'b1;
            dll_reset  <= 1'b0;
            dll_tmr    <= '0;
        end else begin
            dll_reset <= 1'b0;
            if (cmd_sre) begin
                dll_enable <= 1'b0;
                dll_tmr    <= '0;
            end else if (state == drr_pkg::ST_SELF &&
                         next_state == drr_pkg::ST_EXIT) begin
                dll_enable <= 1'b1;
                dll_reset  <= 1'b1;
                dll_tmr    <= drr_pkg::TMR_W'(DLL_DLY);
            end else if (dll_tmr != '0) begin
                dll_tmr <= dll_tmr - drr_pkg::TMR_W'(1);
            end
        end
    end

    // Status outputs
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            banks_idle      <= 1'b1;
            in_self_refresh <= 1'b0;
            odt_active      <= 1'b0;
        end else begin
            banks_idle      <= (next_state != drr_pkg::ST_REFRESH);
            in_self_refresh <= (next_state == drr_pkg::ST_SELF);
            // Termination is dropped whenever self-refresh is involved
            odt_active      <= odt && next_state == drr_pkg::ST_IDLE &&
                               !cmd_sre;
        end
    end

    assign cmd_ready     = (state == drr_pkg::ST_IDLE);
    assign dll_cmd_ready = cmd_ready && dll_tmr == '0 && dll_enable;

    // Assertions; busy windows last the four cycles of the timer load
    sequence s_ref_cmd;
        cmd_ref;
    endsequence

    sequence s_sr_exit;
        state == drr_pkg::ST_SELF && next_state == drr_pkg::ST_EXIT;
    endsequence

    a_refresh_busy: assert property (
        @(posedge clk_sys) disable iff (srst)
        s_ref_cmd |=> !cmd_ready [*4] ##1 cmd_ready)
        else $error("refresh busy window wrong");
    a_row_advance: assert property (
        @(posedge clk_sys) disable iff (srst)
        refresh_strobe |=>
            refresh_row == $past(refresh_row) + drr_pkg::ROW_W'(1))
        else $error("refresh row did not advance");
    a_banks_after: assert property (
        @(posedge clk_sys) disable iff (srst)
        s_ref_cmd |=> !banks_idle ##4 banks_idle)
        else $error("banks not idle after refresh");
    a_sre_enter: assert property (
        @(posedge clk_sys) disable iff (srst)
        cmd_sre |=> in_self_refresh && !dll_enable)
        else $error("self-refresh entry not taken");
    a_sr_hold: assert property (
        @(posedge clk_sys) disable iff (srst)
        state == drr_pkg::ST_SELF && !cke |=> state == drr_pkg::ST_SELF)
        else $error("left self-refresh without CKE");
    a_dll_relock: assert property (
        @(posedge clk_sys) disable iff (srst)
        $rose(dll_reset) |-> dll_enable && !dll_cmd_ready)
        else $error("DLL not relocking on exit");
    a_sr_refresh: assert property (
        @(posedge clk_sys) disable iff (srst)
        cmd_sre |=> ##1 refresh_strobe)
        else $error("no internal refresh after entry");
    a_exit_delay: assert property (
        @(posedge clk_sys) disable iff (srst)
        s_sr_exit |=> !cmd_ready [*4] ##1 cmd_ready)
        else $error("exit delay wrong");
    a_odt_off: assert property (
        @(posedge clk_sys) disable iff (srst)
        in_self_refresh |-> !odt_active)
        else $error("termination on in self-refresh");
endmodule // drr_refresh_ctrl

// file: tb/drr_ctl_model.sv
// Controller model: drives the command pins and clock enable.
// Assumes the bench calls its tasks; pins move 5 ns after rising edges.
`timescale 1ns/1ps
module drr_ctl_model (
    // Clock and status
    input  wire logic clk_sys,
    input  wire logic cmd_ready,
    // Command pins
    output logic      cke,
    output logic      cs_n,
    output logic      ras_n,
    output logic      cas_n,
    output logic      we_n,
    output logic      odt
);
    int   n_due  = 0;
    int   n_sent = 0;
    int   ivl    = 0;
    logic budget_ok;

    // Deselect with clock enable high and termination off
    initial begin
        {cke, cs_n, ras_n, cas_n, we_n, odt} = 6'h3e;
    end

    // One refresh falls due per average interval
    always @(posedge clk_sys) begin
        if (ivl == drr_pkg::INT_REF_CYCLES - 1) begin
            ivl   <= 0;
            n_due <= n_due + 1;
        end else begin
            ivl <= ivl + 1;
        end
    end

    // Balance must stay within eight owed and eight ahead
    assign budget_ok = (n_due - n_sent <= 8) &&
                       (n_sent - n_due <= 8);

    // Refresh pattern for one edge, then deselect
    task automatic issue(input logic ce);
        @(posedge clk_sys) #5;
        {cke, cs_n, ras_n, cas_n, we_n} = {ce, 4'h1};
        @(posedge clk_sys) #5;
        cs_n = 1'b1;
    endtask

    // Waits up to 20 cycles for the device to be ready, so no command lands in a shorter busy spell
    task automatic wait_ready();
        for (int i = 0; i < 20 && cmd_ready !== 1'b1; i++)
            @(posedge clk_sys);
    endtask

    // One refresh; pulling in beyond eight earns no credit
    task automatic refresh();
        wait_ready();
        issue(1'b1);
        if (n_sent - n_due < 8)
            n_sent++;
    endtask

    // Owed refreshes first; termination dropped a cycle ahead
    task automatic sr_enter();
        while (n_sent < n_due)
            refresh();
        odt = 1'b0;
        wait_ready();
        issue(1'b0);
    endtask
endmodule // drr_ctl_model

// file: tb/drr_refresh_ctrl_tb.sv
// Bench for the refresh and self-refresh control block.
// Assumes the controller model drives all command pins.
`timescale 1ns/1ps
module drr_refresh_ctrl_tb;
    logic                      clk_sys;
    logic                      srst;
    logic                      cke, cs_n, ras_n, cas_n, we_n, odt;
    logic [drr_pkg::ROW_W-1:0] refresh_row;
    logic                      refresh_strobe, banks_idle, in_self_refresh;
    logic                      dll_enable, dll_reset, odt_active;
    logic                      cmd_ready, dll_cmd_ready;
    logic [14:0]               st;
    int                        n_mismatch = 0;
    int                        num_checks = 0;

    // Status packed for compact compares
    assign st = {7'h00, refresh_strobe, banks_idle, in_self_refresh,
                 dll_enable, dll_reset, odt_active, cmd_ready, dll_cmd_ready};

    // Short counts keep the self-refresh run brief
    drr_refresh_ctrl #(.CKE_MIN(4), .DLL_DLY(8)) DUT (
        .clk_sys(clk_sys), .srst(srst), .cke(cke), .cs_n(cs_n),
        .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .odt(odt),
        .refresh_row(refresh_row), .refresh_strobe(refresh_strobe),
        .banks_idle(banks_idle), .in_self_refresh(in_self_refresh),
        .dll_enable(dll_enable), .dll_reset(dll_reset),
        .odt_active(odt_active), .cmd_ready(cmd_ready),
        .dll_cmd_ready(dll_cmd_ready));

    drr_ctl_model u_ctl (
        .clk_sys(clk_sys), .cmd_ready(cmd_ready), .cke(cke), .cs_n(cs_n),
        .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .odt(odt));

    // 20 MHz clock; never stopped, so it is stable before every exit
    initial begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end

    task automatic chk(input logic [14:0] seen, input logic [14:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: saw %h expected %h",
                     $time, seen, exp);
        end
    endtask

    // Steps to 5 ns past the n-th next rising edge
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys);
        #5;
    endtask

    task automatic t_refresh();
        for (int k = 1; k <= 3; k++) begin
            u_ctl.refresh();
            chk(st, 15'h90);
            cyc(1);
            chk(st, 15'h10);
            chk(refresh_row, 15'(k));
            cyc(3);
            chk(st, 15'h53);
        end
    endtask

    task automatic t_self();
        int i;
        u_ctl.odt = 1'b1;
        cyc(1);
        chk(st & 15'h04, 15'h04);
        u_ctl.sr_enter();
        chk(st & 15'h32, 15'h20);
        cyc(1);
        chk(st & 15'h80, 15'h80);
        // Early wake and stray termination while asleep
        u_ctl.odt = 1'b1;
        u_ctl.cke = 1'b1;
        cyc(1);
        chk(st & 15'h24, 15'h20);
        u_ctl.odt = 1'b0;
        for (i = 0; i < 10 && dll_reset !== 1'b1; i++)
            cyc(1);
        chk(st & 15'h3a, 15'h18);
        cyc(1);
        chk(st & 15'h08, 15'h00);
        cyc(1);
        chk(st & 15'h02, 15'h00);
        cyc(3);
        chk(st & 15'h03, 15'h02);
        cyc(5);
        chk(st & 15'h03, 15'h03);
    endtask

    // Extra refresh after the exit delay, then a second sleep and wake
    task automatic t_reenter();
        int i;
        u_ctl.refresh();
        u_ctl.sr_enter();
        chk(st & 15'h32, 15'h20);
        u_ctl.cke = 1'b1;
        for (i = 0; i < 10 && dll_reset !== 1'b1; i++)
            cyc(1);
        chk(st & 15'h3a, 15'h18);
        chk(refresh_row, 15'h0006);
        // Calibration would go here; this device decodes none
        cyc(9);
        chk(st & 15'h03, 15'h03);
        chk({14'h0000, u_ctl.budget_ok}, 15'h0001);
    endtask

    // Reset while asleep returns every output to its idle value
    task automatic t_reset_sleep();
        u_ctl.sr_enter();
        chk(st & 15'h20, 15'h20);
        srst = 1'b1;
        cyc(1);
        srst = 1'b0;
        u_ctl.cke = 1'b1;
        chk(st, 15'h53);
        chk(refresh_row, 15'h0000);
        cyc(1);
        chk(st, 15'h53);
    endtask

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // Main sequence
    initial begin
        srst = 1'b1;
        repeat (10) @(posedge clk_sys);
        #5 srst = 1'b0;
        chk(st, 15'h53);
        chk(refresh_row, 15'h0000);
        cyc(1);
        t_refresh();
        t_self();
        t_reenter();
        t_reset_sleep();
        report_and_stop();
    end

    // Watchdog at 4000 cycles, far beyond the under 100 cycles expected
    initial begin
        #200000;
        n_mismatch++;
        report_and_stop();
    end
endmodule // drr_refresh_ctrl_tb
